// ---- inc/rdca_pkg.sv ----
package rdca_pkg;

    // ------------------------------------------------------------
    // Widths and system shape
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int CNT_W = 16;
    localparam int NUM_CH = 2;
    localparam logic CH_RD = 1'b0;
    localparam logic CH_WR = 1'b1;
    localparam int NUM_MST = 3;
    localparam int NUM_SLV = 2;
    localparam int MST_CPU = 0;
    localparam int MST_DBG = 1;
    localparam int MST_DMA = 2;
    localparam int SLV_BIT = 15;
    localparam logic [3:0] RAM_REGION = 4'h2;

    // ------------------------------------------------------------
    // Register map (byte offsets, bit 4 picks the channel)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PTR = 8'h00;
    localparam logic [7:0] OFS_MAX = 8'h04;
    localparam logic [7:0] OFS_AMT = 8'h08;
    localparam logic [7:0] OFS_LIST = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    localparam logic [7:0] OFS_STAT = 8'h24;
    localparam logic [7:0] CH_OFS_MASK = 8'h0F;
    localparam int CH_SEL_BIT = 4;
    localparam int LIST_BIT = 0;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_END = 2;
    localparam int ST_ERR = 4;
    localparam int ST_DROP = 6;
    localparam logic [ADDR_W-1:0] PTR_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Bus encodings and states
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;

    typedef enum logic [1:0] {
        RDCA_IDLE = 2'b00,
        RDCA_ADDR = 2'b01,
        RDCA_DATA = 2'b10
    } rdca_state_t;

endpackage

// ---- rtl/rdca_arb.sv ----
`timescale 1ns/1ps

module rdca_arb
    import rdca_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NUM_MST-1:0] req_i,
    input wire logic [NUM_MST-1:0] active_i,
    output logic [NUM_MST-1:0] gnt_o
);

    logic [NUM_MST-1:0] owner;
    logic [NUM_MST-1:0] pick;
    wire held = |(owner & active_i);

    // Lowest index is the highest priority
    always_comb begin
        pick = '0;
        for (int m = NUM_MST - 1; m >= 0; m--) begin
            if (req_i[m]) begin
                pick = '0;
                pick[m] = 1'b1;
            end
        end
    end

    // A paused owner lends the slave; it is never cut mid-beat
    assign gnt_o = held ? owner : pick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            owner <= '0;
        end else begin
            owner <= gnt_o;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_gnt_onehot: assert property ($onehot0(gnt_o))
        else $error("slave granted to two masters");

    a_top_prio: assert property (!held && req_i[0] |-> gnt_o[0])
        else $error("highest priority request not granted");

    a_keep_owner: assert property (
        held |-> (gnt_o & owner & active_i) != '0 && $onehot(gnt_o))
        else $error("owner lost the slave inside a beat");

    a_lend_idle: assert property (
        !held && req_i != '0 |-> gnt_o != '0 && (gnt_o & ~req_i) == '0)
        else $error("idle slave not lent to a waiting master");

endmodule

// ---- rtl/rdca_top.sv ----
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

module rdca_top
    import rdca_pkg::*;
#(
    parameter bit DROP_ON_STALL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [ADDR_W-1:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o,
    input wire logic [31:0] hrdata_i,
    input wire logic hready_i,
    input wire logic hresp_i,
    input wire logic [NUM_MST-2:0] ext_req_i,
    input wire logic [NUM_MST-2:0] ext_slv_i,
    input wire logic [NUM_MST-2:0] ext_active_i,
    output logic [NUM_MST-2:0] ext_gnt_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic rd_done_o,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic wr_end_i,
    output logic wr_done_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] ptr [NUM_CH];
    logic [ADDR_W-1:0] next_ptr [NUM_CH];
    logic [CNT_W-1:0] maxc [NUM_CH];
    logic [CNT_W-1:0] transferred_count [NUM_CH];
    logic [ADDR_W-1:0] w_addr [NUM_CH];
    logic [CNT_W-1:0] w_cnt [NUM_CH];
    logic [NUM_CH-1:0] list_en;
    logic [NUM_CH-1:0] stop_req;
    logic [NUM_CH-1:0] end_flag;
    logic [NUM_CH-1:0] err_flag;
    logic [NUM_CH-1:0] w_busy;
    logic [NUM_CH-1:0] w_done;
    logic [NUM_CH-1:0] w_stop;
    logic [NUM_CH-1:0] start;
    logic [NUM_CH-1:0] step;
    logic [NUM_CH-1:0] stop_set;
    logic [NUM_CH-1:0] err_set;
    logic [NUM_CH-1:0] ext_stop;
    logic [NUM_CH-1:0] hold_full;
    logic [NUM_CH-1:0] wr_ptr_en;
    logic [NUM_CH-1:0] wr_max_en;
    logic [NUM_CH-1:0] wr_list_en;
    logic [31:0] rd_mux;
    logic [31:0] status;
    logic drop_flag;
    logic rd_full;
    logic [7:0] rd_byte;
    logic wr_full;
    logic [7:0] wr_byte;
    rdca_state_t state;
    rdca_state_t next_state;
    logic sel;
    logic next_sel;
    logic [NUM_MST-1:0] mst_req;
    logic [NUM_MST-1:0] mst_act;
    logic [NUM_MST-1:0] mst_slv;
    logic [NUM_MST-1:0] slv_gnt [NUM_SLV];
    logic [NUM_MST-1:0] all_gnt;

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    wire wb_req = wb_cyc_i & wb_stb_i;
    // Writes land at the ack edge, where the master lets go of the request
    wire wb_wr = wb_req & wb_we_i & wb_ack_o;
    wire ch_area = wb_adr_i < OFS_CTRL;
    wire ch_idx = wb_adr_i[CH_SEL_BIT];
    wire [7:0] ch_ofs = wb_adr_i & CH_OFS_MASK;
    wire hit_ctrl = wb_adr_i == OFS_CTRL;
    wire hit_stat = wb_adr_i == OFS_STAT;
    wire [31:0] wb_bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wb_bits = wb_dat_i & wb_bmask;
    // Untouched byte lanes keep the register's current contents
    wire [31:0] wb_merged = (rd_mux & ~wb_bmask) | wb_bits;
    wire clr_drop = wb_wr & hit_stat & wb_bits[ST_DROP];

    assign status = {25'h000_0000, drop_flag, err_flag, end_flag, w_busy};

    always_comb begin
        rd_mux = '0;
        if (ch_area) begin
            case (ch_ofs)
                OFS_PTR: rd_mux = ptr[ch_idx];
                OFS_MAX: rd_mux[CNT_W-1:0] = maxc[ch_idx];
                OFS_AMT: rd_mux[CNT_W-1:0] = transferred_count[ch_idx];
                OFS_LIST: rd_mux[LIST_BIT] = list_en[ch_idx];
                default: rd_mux = '0;
            endcase
        end else if (hit_stat) begin
            rd_mux = status;
        end
    end

    // One wait state; unmapped offsets ack with zero data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Bus master sequencing
    // ------------------------------------------------------------
    wire addr_ok = haddr_o[ADDR_W-1 -: 4] == RAM_REGION;
    wire dma_gnt = all_gnt[MST_DMA];
    wire data_fin = (state == RDCA_DATA) & hready_i;
    wire xfer_ok = data_fin & ~hresp_i;
    wire addr_bad = (state == RDCA_ADDR) & ~addr_ok;
    wire bus_err = addr_bad | (data_fin & hresp_i);
    wire rd_need = w_busy[CH_RD] & ~w_done[CH_RD] & ~rd_full
                   & ~stop_req[CH_RD];
    wire wr_need = wr_full;
    wire [31:0] lane_sh = hrdata_i >> {haddr_o[1:0], 3'b000};

    always_comb begin
        next_state = state;
        next_sel = sel;
        unique case (state)
            RDCA_IDLE: begin
                if (wr_need | rd_need) begin
                    next_sel = wr_need ? CH_WR : CH_RD;
                    next_state = RDCA_ADDR;
                end
            end
            RDCA_ADDR: begin
                if (!addr_ok) begin
                    next_state = RDCA_IDLE;
                end else if (dma_gnt & hready_i) begin
                    next_state = RDCA_DATA;
                end
            end
            RDCA_DATA: begin
                if (hready_i) begin
                    next_state = RDCA_IDLE;
                end
            end
            default: next_state = RDCA_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= RDCA_IDLE;
            sel <= CH_RD;
            haddr_o <= PTR_RST;
            hwrite_o <= 1'b0;
            hwdata_o <= '0;
        end else begin
            state <= next_state;
            if (state == RDCA_IDLE) begin
                sel <= next_sel;
                haddr_o <= w_addr[next_sel];
                hwrite_o <= next_sel == CH_WR;
                hwdata_o <= {4{wr_byte}};
            end
        end
    end

    // Waiting for the grant simply stalls in the address phase
    assign htrans_o = (state == RDCA_ADDR) & addr_ok & dma_gnt
                      ? HTRANS_NONSEQ : HTRANS_IDLE;
    assign hsize_o = HSIZE_BYTE;

    // ------------------------------------------------------------
    // Peripheral byte holds
    // ------------------------------------------------------------
    wire wr_take = wr_valid_i & wr_ready_o;
    wire wr_lost = wr_take & wr_full & ~step[CH_WR];
    wire wr_abort = err_set[CH_WR] | start[CH_WR];

    // Drop variant never back-pressures on a full hold, so an overrun loses a byte
    assign wr_ready_o = w_busy[CH_WR] & ~stop_req[CH_WR]
                        & (DROP_ON_STALL | ~wr_full);
    assign rd_valid_o = rd_full;
    assign rd_data_o = rd_byte;
    assign rd_done_o = w_done[CH_RD];
    assign wr_done_o = w_done[CH_WR];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_full <= 1'b0;
            rd_byte <= '0;
        end else if (step[CH_RD]) begin
            rd_full <= 1'b1;
            rd_byte <= lane_sh[7:0];
        end else if (rd_valid_o & rd_ready_i) begin
            rd_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_full <= 1'b0;
            wr_byte <= '0;
            drop_flag <= 1'b0;
        end else begin
            if (wr_abort) begin
                wr_full <= 1'b0;
            end else if (step[CH_WR]) begin
                wr_full <= wr_take;
            end else if (wr_take) begin
                wr_full <= 1'b1;
            end
            if (wr_take & (~wr_full | step[CH_WR])) begin
                wr_byte <= wr_data_i;
            end
            drop_flag <= wr_lost | (drop_flag & ~clr_drop);
        end
    end

    assign ext_stop[CH_RD] = 1'b0;
    assign ext_stop[CH_WR] = wr_end_i;
    assign hold_full[CH_RD] = 1'b0;
    assign hold_full[CH_WR] = wr_full;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        wire here = ch_area & (ch_idx == 1'(c));
        wire mine = sel == 1'(c);
        wire quiet = ~((state != RDCA_IDLE) & mine) & ~hold_full[c];

        assign wr_ptr_en[c] = wb_wr & here & (ch_ofs == OFS_PTR);
        assign wr_max_en[c] = wb_wr & here & (ch_ofs == OFS_MAX);
        assign wr_list_en[c] = wb_wr & here & (ch_ofs == OFS_LIST);
        assign start[c] = wb_wr & hit_ctrl & wb_bits[CTRL_START + c]
                          & ~w_busy[c];
        assign step[c] = xfer_ok & mine;
        assign err_set[c] = bus_err & mine;
        assign stop_set[c] = (wb_wr & hit_ctrl & wb_bits[CTRL_STOP + c])
                             | err_set[c] | ext_stop[c];
        // Early end waits until the last held byte reached RAM
        assign w_stop[c] = stop_req[c] & quiet;
        assign next_ptr[c] = wr_ptr_en[c] ? wb_merged
            : (w_done[c] & list_en[c])
            ? ptr[c] + {{(ADDR_W - CNT_W){1'b0}}, maxc[c]}
            : ptr[c];

        rdca_walk u_walk (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .start_i(start[c]),
            .stop_i(w_stop[c]),
            .step_i(step[c]),
            .ptr_i(ptr[c]),
            .max_i(maxc[c]),
            .addr_o(w_addr[c]),
            .count_o(w_cnt[c]),
            .busy_o(w_busy[c]),
            .done_o(w_done[c])
        );

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ptr[c] <= PTR_RST;
                maxc[c] <= CNT_RST;
                transferred_count[c] <= CNT_RST;
                list_en[c] <= 1'b0;
                stop_req[c] <= 1'b0;
                end_flag[c] <= 1'b0;
                err_flag[c] <= 1'b0;
            end else begin
                ptr[c] <= next_ptr[c];
                if (wr_max_en[c]) begin
                    maxc[c] <= wb_merged[CNT_W-1:0];
                end
                if (wr_list_en[c]) begin
                    list_en[c] <= wb_merged[LIST_BIT];
                end
                if (w_done[c]) begin
                    transferred_count[c] <= w_cnt[c];
                end
                stop_req[c] <= ~start[c] & ~w_done[c]
                               & (stop_req[c] | stop_set[c]);
                end_flag[c] <= w_done[c]
                    | (end_flag[c] & ~(wb_wr & hit_stat
                                       & wb_bits[ST_END + c]));
                err_flag[c] <= err_set[c]
                    | (err_flag[c] & ~(wb_wr & hit_stat
                                       & wb_bits[ST_ERR + c]));
            end
        end
    end

    // ------------------------------------------------------------
    // Slave-port arbitration
    // ------------------------------------------------------------
    // Index order is the priority order: processor, debug, channel
    assign mst_req[MST_DMA] = (state == RDCA_ADDR) & addr_ok;
    assign mst_act[MST_DMA] = state == RDCA_DATA;
    assign mst_slv[MST_DMA] = haddr_o[SLV_BIT];
    assign mst_req[MST_DBG:MST_CPU] = ext_req_i;
    assign mst_act[MST_DBG:MST_CPU] = ext_active_i;
    assign mst_slv[MST_DBG:MST_CPU] = ext_slv_i;

    // One arbiter per RAM slave, so disjoint targets never wait
    for (genvar s = 0; s < NUM_SLV; s++) begin : g_slv
        wire [NUM_MST-1:0] on_slv = (s == 1) ? mst_slv : ~mst_slv;

        rdca_arb u_arb (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .req_i(mst_req & on_slv),
            .active_i(mst_act & on_slv),
            .gnt_o(slv_gnt[s])
        );
    end

    assign all_gnt = slv_gnt[0] | slv_gnt[1];
    assign ext_gnt_o = all_gnt[MST_DBG:MST_CPU];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [CNT_W-1:0] wr_cnt_q;
    logic [ADDR_W-1:0] rd_addr_q;

    always_ff @(posedge clk_i) begin
        wr_cnt_q <= w_cnt[CH_WR];
        rd_addr_q <= w_addr[CH_RD];
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_item_end;
        w_done[CH_RD] && list_en[CH_RD] && !wr_ptr_en[CH_RD]
            && !stop_req[CH_RD] && w_cnt[CH_RD] == maxc[CH_RD];
    endsequence

    sequence s_wait_grant;
        state == RDCA_ADDR && addr_ok && !dma_gnt;
    endsequence

    a_ram_only: assert property (
        htrans_o == HTRANS_NONSEQ |-> haddr_o[ADDR_W-1 -: 4] == RAM_REGION)
        else $error("transfer issued outside data RAM");

    a_stall_hold: assert property (
        s_wait_grant |=> state == RDCA_ADDR && $stable(haddr_o))
        else $error("channel left address phase without grant");

    a_transferred_count_update: assert property (
        w_done[CH_WR] |=> transferred_count[CH_WR] == wr_cnt_q)
        else $error("transferred count not updated at completion");

    a_end_flag: assert property (
        w_done[CH_RD] |=> end_flag[CH_RD] && !w_busy[CH_RD])
        else $error("completion not flagged");

    a_list_step: assert property (
        s_item_end |=> ptr[CH_RD] == rd_addr_q)
        else $error("list pointer did not move to next item");

endmodule

// ---- rtl/rdca_walk.sv ----
`timescale 1ns/1ps

module rdca_walk
    import rdca_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic step_i,
    input wire logic [ADDR_W-1:0] ptr_i,
    input wire logic [CNT_W-1:0] max_i,
    output logic [ADDR_W-1:0] addr_o,
    output logic [CNT_W-1:0] count_o,
    output logic busy_o,
    output logic done_o
);

    // Limit is latched so a mid-transfer rewrite cannot move the end
    logic [CNT_W-1:0] limit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_o <= PTR_RST;
            count_o <= CNT_RST;
            limit <= CNT_RST;
            busy_o <= 1'b0;
        end else if (start_i) begin
            addr_o <= ptr_i;
            count_o <= CNT_RST;
            limit <= max_i;
            busy_o <= 1'b1;
        end else if (done_o) begin
            busy_o <= 1'b0;
        end else if (step_i) begin
            addr_o <= addr_o + 32'h0000_0001;
            count_o <= count_o + 16'h0001;
        end
    end

    assign done_o = busy_o & ((count_o == limit) | stop_i);

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_cnt_bound: assert property (busy_o |-> count_o <= limit)
        else $error("byte count passed the programmed limit");

    a_addr_step: assert property (
        busy_o && !done_o && step_i |=> addr_o == $past(addr_o) + 1)
        else $error("pointer did not advance by one byte");

    a_done_at_max: assert property (
        busy_o && count_o == limit |-> done_o ##1 !busy_o)
        else $error("buffer full but channel kept running");

endmodule

// ---- tb/rdca_ram_model.sv ----
`timescale 1ns/1ps
// ------
// RAM slave: byte beats, random wait states
// ------
module rdca_ram_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [1:0] wait_i,
    output logic [31:0] hrdata_o,
    output logic hready_o,
    output logic hresp_o
);
    logic [7:0] mem [256];
    logic dph, dwr;
    logic [7:0] da;
    logic [1:0] wc;
    assign hready_o = !dph || wc == 2'h0;
    assign hresp_o = 1'b0;
    // Other lanes carry the inverse, so a wrong lane pick shows
    always_comb begin
        hrdata_o = {4{~mem[da]}};
        if (dph) hrdata_o[8*da[1:0]+:8] = mem[da];
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            dph <= 1'b0;
            wc <= 2'h0;
        end else if (hready_o) begin
            if (dph && dwr) mem[da] <= hwdata_i[8*da[1:0]+:8];
            dph <= htrans_i == 2'h2;
            da <= haddr_i[7:0];
            dwr <= hwrite_i;
            wc <= wait_i;
        end else begin
            wc <= wc - 2'h1;
        end
    end
endmodule

// ---- tb/tb_rdca_top.sv ----
`timescale 1ns/1ps
module tb_rdca_top;
    import rdca_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 0, stb = 0, we = 0, rdr = 0, wrv = 0, wre = 0, arb = 0;
    logic [7:0] adr = '0, wrd = '0, rdd;
    logic [31:0] dat = '0, wbq, haddr, hwdata, hrdata, q, p;
    logic [1:0] htrans, xreq = '0, xslv = '0, xgnt, ws = '0, xact = '0, na;
    logic [2:0] hsz;
    logic ack, hwrite, hready, hresp, rdv, rdn, wrr, wrn;
    logic [15:0] m;
    logic [7:0] wbuf [8];
    logic [7:0] rq [$];
    int bad_count = 0, num_checks = 0, rd_n = 0, wr_n = 0;
    always #10 clk_i = ~clk_i;
    rdca_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wbq), .wb_ack_o(ack), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsz), .hwdata_o(hwdata), .hrdata_i(hrdata),
        .hready_i(hready), .hresp_i(hresp), .ext_req_i(xreq),
        .ext_slv_i(xslv), .ext_active_i(xact), .ext_gnt_o(xgnt),
        .rd_data_o(rdd), .rd_valid_o(rdv), .rd_ready_i(rdr),
        .rd_done_o(rdn), .wr_data_i(wrd), .wr_valid_i(wrv),
        .wr_ready_o(wrr), .wr_end_i(wre), .wr_done_o(wrn));
    rdca_ram_model RAM (
        .clk_i(clk_i), .rst_i(rst_i), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hwdata_i(hwdata), .wait_i(ws),
        .hrdata_o(hrdata), .hready_o(hready), .hresp_o(hresp));
    // ------
    // Tasks
    // ------
    function automatic logic [1:0] gexp(logic [1:0] r, logic [1:0] s,
                                        logic [1:0] a);
        logic same;
        same = s[0] == s[1];
        // A busy owner keeps its slave; the processor outranks debug
        return {a[1] || (r[1] && !(same && (r[0] || a[0]))),
                a[0] || (r[0] && !(same && a[1]))};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = wbq;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wfeed(input int k, input logic e);
        for (int i = 0; i < k; i++) begin
            wrd <= wbuf[i];
            wrv <= 1'b1;
            do @(posedge clk_i); while (wrr !== 1'b1);
        end
        wrv <= 1'b0;
        wre <= e;
        @(posedge clk_i);
        wre <= 1'b0;
    endtask
    task automatic wait_ev(input logic w, input int k);
        while ((w ? wr_n : rd_n) < k) @(posedge clk_i);
        repeat (20) @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------
    // Monitor and random far-side traffic
    // ------
    always @(posedge clk_i) begin
        if (!rst_i && rdv && rdr) rq.push_back(rdd);
        if (!rst_i && rdn) rd_n++;
        if (!rst_i && wrn) wr_n++;
        if (!rst_i && xreq[0] && xslv[0] == haddr[15])
            chk(32'(htrans), 32'(HTRANS_IDLE));
        if (htrans == HTRANS_NONSEQ) begin
            chk(32'(haddr[31:28]), 32'(RAM_REGION));
            chk(32'(hsz), 32'(HSIZE_BYTE));
        end
        if (arb) chk(32'(xgnt), 32'(gexp(xreq, xslv, xact)));
        // Only a master granted now may stay busy, and on the same slave
        na = rst_i ? 2'h0 : xgnt & 2'($urandom);
        rdr <= 1'($urandom);
        xreq <= 2'($urandom);
        xslv <= (xslv & na) | (2'($urandom) & ~na);
        xact <= na;
        ws <= 2'($urandom_range(2));
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
    // ------
    // Main sequence
    // ------
    initial begin
        void'($urandom(32'h71335c4b));
        foreach (RAM.mem[i]) RAM.mem[i] = 8'($urandom);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (wbuf[i]) begin
            wb(1'b0, 8'(i * 4 + 8'h14), 32'h0, q);
            chk(q, 32'h0);
        end
        for (int j = 0; j < 3; j++) begin
            if (j < 2) begin
                p = 32'h2000_0001 + 32'($urandom_range(40));
                m = j == 0 ? 16'h0 : 16'($urandom_range(8, 1));
                wb(1'b1, OFS_PTR, p, q);
                wb(1'b1, OFS_MAX, 32'(m), q);
                wb(1'b1, OFS_LIST, 32'(j), q);
            end
            rq.delete();
            wb(1'b1, OFS_CTRL, 32'h1, q);
            wait_ev(1'b0, j + 1);
            chk(32'(rq.size()), 32'(m));
            foreach (rq[i])
                chk(32'(rq[i]), 32'(RAM.mem[8'(p[7:0] + i)]));
            wb(1'b0, OFS_AMT, 32'h0, q);
            chk(q, 32'(m));
            if (j > 0) p = p + 32'(m);
            wb(1'b0, OFS_PTR, 32'h0, q);
            chk(q, p);
        end
        for (int k = 3; k <= 6; k += 3) begin
            p = 32'h2000_0080 + 32'(k * 8 + $urandom_range(3));
            foreach (wbuf[i]) wbuf[i] = 8'($urandom);
            wb(1'b1, 8'h10 | OFS_PTR, p, q);
            wb(1'b1, 8'h10 | OFS_MAX, 32'h6, q);
            wb(1'b1, OFS_CTRL, 32'h2, q);
            wfeed(k, k < 6);
            wait_ev(1'b1, k / 3);
            wb(1'b0, 8'h10 | OFS_AMT, 32'h0, q);
            chk(q, 32'(k));
            chk(32'(wrr), 32'h0);
            for (int i = 0; i < k; i++)
                chk(32'(RAM.mem[8'(p[7:0] + i)]), 32'(wbuf[i]));
        end
        wb(1'b1, OFS_LIST, 32'h0, q);
        wb(1'b1, OFS_PTR, 32'h1000_0000, q);
        wb(1'b1, OFS_CTRL, 32'h1, q);
        repeat (10) @(posedge clk_i);
        wb(1'b0, OFS_STAT, 32'h0, q);
        chk(q, (32'h1 << ST_ERR) | (32'h3 << ST_END));
        wb(1'b1, OFS_STAT, 32'h0000_00FF, q);
        wb(1'b0, OFS_STAT, 32'h0, q);
        chk(q, 32'h0);
        arb <= 1'b1;
        repeat (300) @(posedge clk_i);
        finish_test();
    end
endmodule
